// File: inc/rzf_regs.svh
// register map, field positions, frame constants for the route/zdo framer
`ifndef RZF_REGS_SVH
`define RZF_REGS_SVH
`define RZF_OFF_CTRL      8'h00
`define RZF_OFF_MAXHOPS   8'h04
`define RZF_OFF_STATUS    8'h08
`define RZF_OFF_MASK      8'h0C
`define RZF_OFF_LASTCMD   8'h10
`define RZF_OFF_COUNT     8'h14
`define RZF_CTRL_FRAMED   0
`define RZF_CTRL_RXFMT    1
`define RZF_CTRL_RESET    2'h1
`define RZF_MAXHOPS_RESET 8'h1E
`define RZF_IRQ_ROUTEREQ  0
`define RZF_IRQ_RXOK      1
`define RZF_IRQ_RXBAD     2
`define RZF_IRQ_SUPPRESS  3
`define RZF_IRQ_W         4
`define RZF_DELIM         8'h7E
`define RZF_TYPE_IND      8'hA3
`define RZF_TYPE_XMIT     8'h11
`define RZF_TYPE_STAT     8'h8B
`define RZF_IND_LEN       8'h0C
`define RZF_STAT_LEN      8'h07
`define RZF_OFS_TYPE      16'd3
`define RZF_OFS_PAYLOAD   16'd23
`endif

// File: inc/rzf_pkg.sv
// types shared by the route/zdo framer modules
package rzf_pkg;
  typedef enum logic [2:0] {
    EM_IDLE, EM_DELIM, EM_LENH, EM_LENL, EM_DATA, EM_CSUM
  } rzf_emit_state_type;
  typedef enum logic [2:0] {
    PA_HUNT, PA_LENH, PA_LENL, PA_DATA, PA_CSUM
  } rzf_parse_state_type;
endpackage

// File: rtl/rzf_frame_emit.sv
// api frame serialiser
`timescale 1ns/100ps
`include "rzf_regs.svh"
module rzf_frame_emit
  import rzf_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // frame request
  input  wire logic        start,
  input  wire logic [7:0]  frameLen,
  input  wire logic [95:0] frameData,
  output logic             busy,
  // byte stream out
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady
);
  rzf_emit_state_type state_r;
  logic [95:0]        buf_r;
  logic [7:0]         len_r;
  logic [7:0]         idx_r;
  logic [7:0]         sum_r;
  logic [7:0]         byte_r;
  logic               fire;

  assign txValid = (state_r != EM_IDLE);
  assign busy    = txValid;
  assign txData  = byte_r;
  assign fire    = txValid && txReady;

  // ----------------------------------------
  // envelope sequencer
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= EM_IDLE;
      buf_r   <= 96'h0;
      len_r   <= 8'h00;
      idx_r   <= 8'h00;
      sum_r   <= 8'h00;
      byte_r  <= 8'h00;
    end else begin
      case (state_r)
        EM_IDLE: begin
          if (start) begin
            byte_r  <= `RZF_DELIM;  // see [RULE5]
            buf_r   <= frameData;
            len_r   <= frameLen;
            sum_r   <= 8'h00;
            idx_r   <= 8'h00;
            state_r <= EM_DELIM;
          end
        end
        EM_DELIM: if (fire) begin
          byte_r  <= 8'h00;
          state_r <= EM_LENH;
        end
        EM_LENH: if (fire) begin
          byte_r  <= len_r;
          state_r <= EM_LENL;
        end
        EM_LENL: if (fire) begin
          byte_r  <= buf_r[95:88];
          buf_r   <= buf_r << 8;
          state_r <= EM_DATA;
        end
        EM_DATA: if (fire) begin
          sum_r <= sum_r + byte_r;
          if (idx_r == len_r - 8'h01) begin
            byte_r  <= 8'hFF - (sum_r + byte_r);  // see [RULE5]
            state_r <= EM_CSUM;
          end else begin
            idx_r  <= idx_r + 8'h01;
            byte_r <= buf_r[95:88];
            buf_r  <= buf_r << 8;
          end
        end
        EM_CSUM: if (fire) begin
          state_r <= EM_IDLE;
        end
        default: state_r <= EM_IDLE;
      endcase
    end
  end
endmodule // rzf_frame_emit

// File: rtl/rzf_frame_parse.sv
// api frame deframer
`timescale 1ns/100ps
`include "rzf_regs.svh"
module rzf_frame_parse
  import rzf_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // byte stream in
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  // decoded bytes
  output logic [7:0]       byteData,
  output logic [15:0]      byteOfs,
  output logic             byteStrobe,
  output logic             frameOk,
  output logic             frameBad
);
  rzf_parse_state_type state_r;
  logic [15:0]         len_r;
  logic [15:0]         ofs_r;
  logic [7:0]          sum_r;

  // ----------------------------------------
  // envelope tracking
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r    <= PA_HUNT;
      len_r      <= 16'h0000;
      ofs_r      <= 16'h0000;
      sum_r      <= 8'h00;
      byteData   <= 8'h00;
      byteOfs    <= 16'h0000;
      byteStrobe <= 1'b0;
      frameOk    <= 1'b0;
      frameBad   <= 1'b0;
    end else begin
      byteStrobe <= 1'b0;
      frameOk    <= 1'b0;
      frameBad   <= 1'b0;
      if (rxValid) begin
        case (state_r)
          PA_HUNT: if (rxData == `RZF_DELIM) state_r <= PA_LENH;  // see [RULE5]
          PA_LENH: begin
            len_r[15:8] <= rxData;
            state_r     <= PA_LENL;
          end
          PA_LENL: begin
            len_r[7:0] <= rxData;
            ofs_r      <= `RZF_OFS_TYPE;
            sum_r      <= 8'h00;
            state_r    <= ({len_r[15:8], rxData} == 16'h0000) ? PA_HUNT
                                                               : PA_DATA;
          end
          PA_DATA: begin
            byteData   <= rxData;
            byteOfs    <= ofs_r;
            byteStrobe <= 1'b1;
            sum_r      <= sum_r + rxData;
            ofs_r      <= ofs_r + 16'h0001;
            if (ofs_r == len_r + 16'h0002) state_r <= PA_CSUM;
          end
          PA_CSUM: begin
            frameOk  <= ((sum_r + rxData) == 8'hFF);  // see [RULE5]
            frameBad <= ((sum_r + rxData) != 8'hFF);
            state_r  <= PA_HUNT;
          end
          default: state_r <= PA_HUNT;
        endcase
      end
    end
  end
endmodule // rzf_frame_parse

// File: rtl/rzf_top.sv
// route indicator and explicit transmit framer
//
// Overview of operation
// [RULE1] Route request received: emit indicator frame of type A3.
// [RULE2] Indicator only while framed api mode is on.
// [RULE3] Requester 64-bit address in bytes 4-11, msb first.
// [RULE4] Initiator 16-bit address bytes 12-13 msb first; byte 14 zero.
// [RULE5] Frame: 7E, length msb first, data, checksum.
// [RULE6] Host commands arrive in explicit transmit frames, type 11.
// [RULE7] Correlation byte 4 zero suppresses transmit status.
// [RULE8] Destination 64-bit in bytes 5-12; FFFF is broadcast.
// [RULE9] Destination 16-bit in bytes 13-14; FFFE broadcast or unknown.
// [RULE10] Endpoint bytes 15 and 16 zero for management.
// [RULE11] Cluster in bytes 17-18, msb first.
// [RULE12] Profile bytes 19-20 zero for management.
// [RULE13] Radius byte 21 zero becomes maximum hop count.
// [RULE14] Options byte 22 all zero for management.
// [RULE15] Payload from byte 23, parameters least significant first.
// [RULE16] Active endpoints: cluster 0005, target address little endian.
// [RULE17] Receive format option one selects explicit receive frames.
// [RULE18] Management clusters follow the fixed cluster code table.
`timescale 1ns/100ps
`include "rzf_regs.svh"
module rzf_top
  import rzf_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // interrupt
  output logic             irq,
  // network side events
  input  wire logic        routeReqValid,
  input  wire logic [63:0] routeReqAddr64,
  input  wire logic [15:0] routeReqAddr16,
  input  wire logic        netDoneValid,
  input  wire logic [7:0]  netDoneStatus,
  // serial port towards host
  output logic [7:0]       serTxData,
  output logic             serTxValid,
  input  wire logic        serTxReady,
  input  wire logic [7:0]  serRxData,
  input  wire logic        serRxValid,
  // explicit transmit request to network
  output logic             xmitValid,
  output logic             xmitDrop,
  output logic [7:0]       xmitFrameId,
  output logic [63:0]      xmitDest64,
  output logic [15:0]      xmitDest16,
  output logic [7:0]       xmitSrcEp,
  output logic [7:0]       xmitDstEp,
  output logic [15:0]      xmitCluster,
  output logic [15:0]      xmitProfile,
  output logic [7:0]       xmitRadius,
  output logic [7:0]       xmitOptions,
  output logic [7:0]       plData,
  output logic             plValid,
  // mode outputs
  output logic             framedMode,
  output logic             receive_frame_format_option
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [1:0]  ctrl_r;
  logic [7:0]  maxHops_r;
  logic [`RZF_IRQ_W-1:0] status_r;
  logic [`RZF_IRQ_W-1:0] mask_r;
  logic [`RZF_IRQ_W-1:0] evt;
  logic [15:0] indCount_r;
  logic [15:0] rxCount_r;
  logic        dpWr_r;
  logic        dpRd_r;
  logic [7:0]  dpAddr_r;
  logic        readWait_r;
  logic        apAcc;
  logic [31:0] rdValue;
  logic        indPend_r;
  logic [63:0] indAddr64_r;
  logic [15:0] indAddr16_r;
  logic        statPend_r;
  logic [7:0]  statFrameId_r;
  logic [15:0] statDest16_r;
  logic [7:0]  statCode_r;
  logic        emStart;
  logic [7:0]  emLen;
  logic [95:0] emData;
  logic        emBusy;
  logic        emIsInd;
  logic [7:0]  pbData;
  logic [15:0] pbOfs;
  logic        pbStrobe;
  logic        pbOk;
  logic        pbBad;
  logic        typeOk_r;
  logic [7:0]  wFrameId_r;
  logic [63:0] wDest64_r;
  logic [15:0] wDest16_r;
  logic [7:0]  wSrcEp_r;
  logic [7:0]  wDstEp_r;
  logic [15:0] wCluster_r;
  logic [15:0] wProfile_r;
  logic [7:0]  wRadius_r;
  logic [7:0]  wOptions_r;
  function automatic logic regHit(input logic [7:0] a, input logic [7:0] o);
    regHit = (a == o);
  endfunction
  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  assign apAcc     = hsel && htrans[1] && hready;
  assign hreadyout = !readWait_r;
  assign hresp     = 1'b0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dpWr_r     <= 1'b0;
      dpRd_r     <= 1'b0;
      dpAddr_r   <= 8'h00;
      readWait_r <= 1'b0;
    end else begin
      readWait_r <= apAcc && !hwrite;
      if (apAcc) begin
        dpWr_r   <= hwrite;
        dpRd_r   <= !hwrite;
        dpAddr_r <= haddr[7:0];
      end else if (hready) begin
        dpWr_r <= 1'b0;
        dpRd_r <= 1'b0;
      end
    end
  end
  always_comb begin
    rdValue = 32'h0000_0000;
    if (regHit(dpAddr_r, `RZF_OFF_CTRL))    rdValue[1:0] = ctrl_r;
    if (regHit(dpAddr_r, `RZF_OFF_MAXHOPS)) rdValue[7:0] = maxHops_r;
    if (regHit(dpAddr_r, `RZF_OFF_STATUS))  rdValue[`RZF_IRQ_W-1:0] = status_r;
    if (regHit(dpAddr_r, `RZF_OFF_MASK))    rdValue[`RZF_IRQ_W-1:0] = mask_r;
    if (regHit(dpAddr_r, `RZF_OFF_LASTCMD)) rdValue = {xmitProfile, xmitCluster};
    if (regHit(dpAddr_r, `RZF_OFF_COUNT))   rdValue = {rxCount_r, indCount_r};
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (readWait_r) begin
      hrdata <= rdValue;
    end
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r    <= `RZF_CTRL_RESET;
      maxHops_r <= `RZF_MAXHOPS_RESET;
      mask_r    <= {`RZF_IRQ_W{1'b0}};
    end else if (dpWr_r) begin
      if (regHit(dpAddr_r, `RZF_OFF_CTRL))    ctrl_r    <= hwdata[1:0];
      if (regHit(dpAddr_r, `RZF_OFF_MAXHOPS)) maxHops_r <= hwdata[7:0];
      if (regHit(dpAddr_r, `RZF_OFF_MASK))
        mask_r <= hwdata[`RZF_IRQ_W-1:0];
    end
  end
  assign framedMode                  = ctrl_r[`RZF_CTRL_FRAMED];
  assign receive_frame_format_option = ctrl_r[`RZF_CTRL_RXFMT];  // see [RULE17]
  // ----------------------------------------
  // interrupt status, cleared by read
  // ----------------------------------------
  always_comb begin
    evt = {`RZF_IRQ_W{1'b0}};
    evt[`RZF_IRQ_ROUTEREQ] = routeReqValid && framedMode;
    evt[`RZF_IRQ_RXOK]     = pbOk && typeOk_r;
    evt[`RZF_IRQ_RXBAD]    = pbBad;
    evt[`RZF_IRQ_SUPPRESS] = netDoneValid && (wFrameId_r == 8'h00);
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_r <= {`RZF_IRQ_W{1'b0}};
    end else if (readWait_r && regHit(dpAddr_r, `RZF_OFF_STATUS)) begin
      status_r <= (status_r & ~rdValue[`RZF_IRQ_W-1:0]) | evt;
    end else begin
      status_r <= status_r | evt;
    end
  end
  assign irq = |(status_r & mask_r);
  // ----------------------------------------
  // route request capture
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      indPend_r   <= 1'b0;
      indAddr64_r <= 64'h0;
      indAddr16_r <= 16'h0000;
    end else if (routeReqValid && framedMode) begin  // see [RULE2]
      indPend_r   <= 1'b1;
      indAddr64_r <= routeReqAddr64;
      indAddr16_r <= routeReqAddr16;
    end else if (emStart && emIsInd) begin
      indPend_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // transmit status capture
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      statPend_r    <= 1'b0;
      statFrameId_r <= 8'h00;
      statDest16_r  <= 16'h0000;
      statCode_r    <= 8'h00;
    end else if (netDoneValid && (wFrameId_r != 8'h00)) begin  // see [RULE7]
      statPend_r    <= 1'b1;
      statFrameId_r <= wFrameId_r;
      statDest16_r  <= wDest16_r;
      statCode_r    <= netDoneStatus;
    end else if (emStart && !emIsInd) begin
      statPend_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // frame builder and emitter
  // ----------------------------------------
  assign emIsInd = indPend_r;
  assign emStart = !emBusy && (indPend_r || statPend_r);

  always_comb begin
    if (emIsInd) begin
      emLen  = `RZF_IND_LEN;
      emData = {`RZF_TYPE_IND,  // see [RULE1]
                indAddr64_r,    // see [RULE3]
                indAddr16_r,    // see [RULE4]
                8'h00};         // see [RULE4]
    end else begin
      emLen  = `RZF_STAT_LEN;
      emData = {`RZF_TYPE_STAT, statFrameId_r, statDest16_r,
                8'h00, statCode_r, 8'h00, 40'h0};
    end
  end

  rzf_frame_emit u_emit (
    .mclk      (mclk),
    .rst       (rst),
    .start     (emStart),
    .frameLen  (emLen),
    .frameData (emData),
    .busy      (emBusy),
    .txData    (serTxData),
    .txValid   (serTxValid),
    .txReady   (serTxReady)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      indCount_r <= 16'h0000;
    end else if (emStart && emIsInd) begin
      indCount_r <= indCount_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // explicit transmit frame decode
  // ----------------------------------------
  rzf_frame_parse u_parse (
    .mclk       (mclk),
    .rst        (rst),
    .rxData     (serRxData),
    .rxValid    (serRxValid),
    .byteData   (pbData),
    .byteOfs    (pbOfs),
    .byteStrobe (pbStrobe),
    .frameOk    (pbOk),
    .frameBad   (pbBad)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      typeOk_r   <= 1'b0;
      wFrameId_r <= 8'h00;
      wDest64_r  <= 64'h0;
      wDest16_r  <= 16'h0000;
      wSrcEp_r   <= 8'h00;
      wDstEp_r   <= 8'h00;
      wCluster_r <= 16'h0000;
      wProfile_r <= 16'h0000;
      wRadius_r  <= 8'h00;
      wOptions_r <= 8'h00;
    end else if (pbStrobe) begin
      case (pbOfs[7:0])
        8'd3:  typeOk_r   <= (pbData == `RZF_TYPE_XMIT);  // see [RULE6]
        8'd4:  wFrameId_r <= pbData;                      // see [RULE7]
        8'd5, 8'd6, 8'd7, 8'd8, 8'd9, 8'd10, 8'd11, 8'd12:
               wDest64_r  <= {wDest64_r[55:0], pbData};   // see [RULE8]
        8'd13: wDest16_r[15:8] <= pbData;                 // see [RULE9]
        8'd14: wDest16_r[7:0]  <= pbData;
        8'd15: wSrcEp_r   <= pbData;                      // see [RULE10]
        8'd16: wDstEp_r   <= pbData;
        8'd17: wCluster_r[15:8] <= pbData;                // see [RULE11]
        8'd18: wCluster_r[7:0]  <= pbData;
        8'd19: wProfile_r[15:8] <= pbData;                // see [RULE12]
        8'd20: wProfile_r[7:0]  <= pbData;
        8'd21: wRadius_r  <= (pbData == 8'h00) ? maxHops_r
                                               : pbData;  // see [RULE13]
        8'd22: wOptions_r <= pbData;                      // see [RULE14]
        default: ;
      endcase
    end
  end
  // payload bytes untouched
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      plData  <= 8'h00;
      plValid <= 1'b0;
    end else begin
      plValid <= pbStrobe && typeOk_r && (pbOfs >= `RZF_OFS_PAYLOAD);
      if (pbStrobe) plData <= pbData;  // see [RULE15]
    end
  end
  // ----------------------------------------
  // commit of a checked frame
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xmitValid   <= 1'b0;
      xmitDrop    <= 1'b0;
      xmitFrameId <= 8'h00;
      xmitDest64  <= 64'h0;
      xmitDest16  <= 16'h0000;
      xmitSrcEp   <= 8'h00;
      xmitDstEp   <= 8'h00;
      xmitCluster <= 16'h0000;
      xmitProfile <= 16'h0000;
      xmitRadius  <= 8'h00;
      xmitOptions <= 8'h00;
      rxCount_r   <= 16'h0000;
    end else begin
      xmitValid <= pbOk && typeOk_r;
      xmitDrop  <= pbBad && typeOk_r;
      if (pbOk && typeOk_r) begin
        xmitFrameId <= wFrameId_r;
        xmitDest64  <= wDest64_r;
        xmitDest16  <= wDest16_r;
        xmitSrcEp   <= wSrcEp_r;
        xmitDstEp   <= wDstEp_r;
        xmitCluster <= wCluster_r;  // see [RULE18]
        xmitProfile <= wProfile_r;
        xmitRadius  <= wRadius_r;
        xmitOptions <= wOptions_r;
        rxCount_r   <= rxCount_r + 16'h0001;
      end
    end
  end
endmodule // rzf_top

// File: verif/rzf_top_props.sv
// assertions on the serial frames and transmit fields of the framer
`timescale 1ns/100ps
module rzf_top_props (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // observed ports
  input wire logic [7:0] serTxData,
  input wire logic       serTxValid,
  input wire logic       serTxReady,
  input wire logic       routeReqValid,
  input wire logic       framedMode,
  input wire logic       netDoneValid,
  input wire logic [7:0] xmitFrameId,
  input wire logic       xmitValid,
  input wire logic [7:0] xmitRadius
);
  // ----------------------------------------
  // byte position inside the outgoing frame
  // ----------------------------------------
  logic [7:0] bIdx_r;
  logic [7:0] bLen_r;
  logic [7:0] bTyp_r;
  logic [7:0] bSum_r;
  logic       beat;
  assign beat = serTxValid && serTxReady;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bIdx_r <= 8'h00;
      bLen_r <= 8'h00;
      bTyp_r <= 8'h00;
      bSum_r <= 8'h00;
    end else if (beat) begin
      bIdx_r <= (bIdx_r > 8'h03 && bIdx_r == bLen_r + 8'h03) ? 8'h00
                : bIdx_r + 8'h01;
      if (bIdx_r == 8'h02) bLen_r <= serTxData;
      if (bIdx_r == 8'h03) bTyp_r <= serTxData;
      bSum_r <= (bIdx_r < 8'h03) ? 8'h00 : bSum_r + serTxData;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_delim;
    serTxValid && serTxData == 8'h7E;
  endsequence
  sequence s_quiet;
    !serTxValid [*4];
  endsequence
  a_frame_delim: assert property (beat && bIdx_r == 8'h00
    |-> s_delim) else $error("no delimiter");
  a_len_high: assert property (beat && bIdx_r == 8'h01
    |-> serTxData == 8'h00) else $error("length high");
  a_frame_sum: assert property (beat && bIdx_r > 8'h03
    && bIdx_r == bLen_r + 8'h03 |-> 8'(bSum_r + serTxData) == 8'hFF)
    else $error("checksum");
  a_tx_hold: assert property (serTxValid && !serTxReady
    |=> serTxValid && $stable(serTxData)) else $error("byte dropped");
  a_ind_len: assert property (beat && bIdx_r == 8'h03
    && serTxData == 8'hA3 |-> bLen_r == 8'h0C) else $error("ind length");
  a_ind_rsvd: assert property (beat && bIdx_r == 8'h0E
    && bTyp_r == 8'hA3 |-> serTxData == 8'h00) else $error("reserved");
  a_ind_start: assert property (routeReqValid && framedMode
    && !serTxValid |-> ##[1:2] s_delim) else $error("no indicator");
  a_unframed_quiet: assert property (routeReqValid
    && !framedMode && !serTxValid && !netDoneValid |=> s_quiet)
    else $error("unframed");
  a_zero_id_quiet: assert property (netDoneValid
    && xmitFrameId == 8'h00 && !serTxValid && !routeReqValid |=> s_quiet)
    else $error("status sent");
  a_radius_set: assert property (xmitValid
    |-> xmitRadius != 8'h00) else $error("zero radius");
endmodule // rzf_top_props

bind rzf_top rzf_top_props u_rzf_top_props (.*);

// File: verif/rzf_host_model.sv
// host processor model on the serial port of the framer
`timescale 1ns/100ps
module rzf_host_model (
  // clock and pacing
  input  wire logic       mclk,
  input  wire logic       slow,
  // frames from the framer
  input  wire logic [7:0] serTxData,
  input  wire logic       serTxValid,
  output logic            serTxReady,
  // frames towards the framer
  output logic [7:0]      serRxData,
  output logic            serRxValid
);
  // ----------------------------------------
  // receive side
  // ----------------------------------------
  logic [7:0] got[$];
  initial begin
    serTxReady = 1'b0;
    serRxData  = 8'h00;
    serRxValid = 1'b0;
  end
  always @(posedge mclk) begin
    if (serTxValid && serTxReady) got.push_back(serTxData);
    serTxReady <= slow ? ~serTxReady : 1'b1;
  end
  // frame envelope
  task automatic send(input logic [7:0] d[$], input logic bad);
    logic [7:0] f[$];
    logic [7:0] s;
    s = 8'h00;
    foreach (d[i]) s += d[i];
    f = {8'h7E, 8'h00, 8'(d.size()), d, (8'hFF - s) ^ {7'h0, bad}};
    foreach (f[i]) begin
      @(posedge mclk);
      serRxValid <= 1'b1;
      serRxData  <= f[i];
    end
    @(posedge mclk);
    serRxValid <= 1'b0;
    serRxData  <= ~f[f.size()-1];
  endtask
endmodule // rzf_host_model

// File: verif/test_rzf_top.sv
// self-checking bench for the route/zdo framer
`timescale 1ns/100ps
module test_rzf_top
  import rzf_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        mclk, rst, hsel, hwrite, routeReqValid, netDoneValid, slow;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [63:0] ra64, xmitDest64;
  logic [15:0] ra16, xmitDest16, xmitCluster, xmitProfile;
  logic [7:0]  serTxData, serRxData, xmitFrameId, xmitRadius, plData;
  logic [7:0]  xmitSrcEp, xmitDstEp, xmitOptions;
  logic        hreadyout, irq, serTxValid, serTxReady, serRxValid;
  logic        xmitValid, xmitDrop, plValid, framedMode, rxFmt, hresp;
  logic [7:0]  pl[$], e[$];
  int          err_total = 0, compares = 0, nOk = 0, nBad = 0;
  rzf_top u_rzf_top (.*, .hsize(3'h2), .hready(hreadyout),
    .routeReqAddr64(ra64), .routeReqAddr16(ra16), .netDoneStatus(8'h00),
    .receive_frame_format_option(rxFmt));
  rzf_host_model u_rzf_host_model (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (xmitValid) nOk++;
    if (xmitDrop) nBad++;
    if (plValid) pl.push_back(plData);
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task conclude;
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, wd);
    int n;
    n = 0;
    @(posedge mclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    chk(hresp === 1'b0, "resp");
    if (n >= 50) begin chk(1'b0, "bus hang"); conclude; end
  endtask
  task automatic waitc(ref int c, input int t);
    int n;
    n = 0;
    while (c < t && n < 80) begin @(posedge mclk); n++; end
    if (c < t) begin chk(1'b0, "no response"); conclude; end
  endtask
  task automatic pulse_done;
    @(posedge mclk); netDoneValid <= 1'b1;
    @(posedge mclk); netDoneValid <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    ahb(0, 32'h0, 0); chk(rd === 32'h1, "ctrl");
    ahb(0, 32'h4, 0); chk(rd === 32'h1E, "hops");
    ahb(1, 32'h40, 32'hFFFFFFFF); ahb(0, 32'h40, 0); chk(rd === 32'h0, "hole");
    ahb(1, 32'h0, 32'h3); ahb(0, 32'h0, 0); chk(rd === 32'h3, "ctrl wr");
    chk(rxFmt === 1'b1, "rxfmt");
    ahb(1, 32'hC, 32'h0);
  endtask
  task automatic t_route(input logic fm);
    int n;
    u_rzf_host_model.got.delete();
    @(posedge mclk);
    routeReqValid <= 1'b1; ra64 <= 64'h0011223344556677; ra16 <= 16'hBEEF;
    @(posedge mclk);
    routeReqValid <= 1'b0; ra64 <= 64'h0; ra16 <= 16'h0;
    n = 0;
    while (u_rzf_host_model.got.size() < 16 && n < 80) begin
      @(posedge mclk);
      n++;
    end
    chk(framedMode === fm, "mode");
    if (!fm) begin
      chk(u_rzf_host_model.got.size() == 0, "unframed");
      return;
    end
    e = {8'h7E, 8'h00, 8'h0C, 8'hA3, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
         8'h66, 8'h77, 8'hBE, 8'hEF, 8'h00, 8'hD3};
    foreach (e[i]) chk(u_rzf_host_model.got[i] === e[i], "ind");
    chk(irq === 1'b0, "masked");
    ahb(1, 32'hC, 32'h1); repeat (2) @(posedge mclk); #1;
    chk(irq === 1'b1, "irq");
    ahb(0, 32'h8, 0); chk(rd[0] === 1'b1, "evt");
    repeat (2) @(posedge mclk); #1;
    chk(irq === 1'b0, "clr");
  endtask
  task automatic t_xmit;
    logic [15:0] cl[11] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004,
      16'h0005, 16'h0006, 16'h0031, 16'h0032, 16'h0034, 16'h0036, 16'h0038};
    logic [7:0] d[$];
    int k;
    for (int i = 0; i < 11; i++) begin
      k = nOk;
      d = {8'h11, 8'(i), 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
           8'hFF, 8'hFF, 8'hFE, 8'h00, 8'h00, cl[i][15:8], cl[i][7:0],
           8'h00, 8'h00, 8'(i), 8'h00, 8'h01, 8'h34, 8'h12};
      u_rzf_host_model.send(d, 1'b0);
      waitc(nOk, k + 1);
      chk(xmitCluster === cl[i], "cluster");
      chk(xmitRadius === (i ? 8'(i) : 8'h1E), "rad");
      chk(xmitFrameId === 8'(i), "id");
      chk(xmitDest16 === 16'hFFFE, "d16");
      chk(xmitDest64 === 64'hFFFF, "d64");
      chk({xmitSrcEp, xmitDstEp} === 16'h0, "ep");
      chk(xmitProfile === 16'h0, "prof");
      chk(xmitOptions === 8'h0, "opt");
      if (i == 0) begin
        u_rzf_host_model.got.delete();
        pulse_done;
        repeat (20) @(posedge mclk);
        chk(u_rzf_host_model.got.size() == 0, "id0");
      end
    end
    chk(pl.size() == 33, "pl count");
    chk(pl[31] === 8'h34 && pl[32] === 8'h12, "pl");
    pulse_done;
    repeat (40) @(posedge mclk);
    chk(u_rzf_host_model.got[3] === 8'h8B, "st type");
    chk(u_rzf_host_model.got[4] === 8'h0A, "st id");
    k = nOk;
    u_rzf_host_model.send(d, 1'b1);
    waitc(nBad, 1);
    chk(nOk == k, "bad taken");
    ahb(0, 32'h14, 0); chk(rd === 32'h000B_0001, "counts");
    ahb(0, 32'h10, 0); chk(rd === 32'h0000_0038, "last");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; routeReqValid = 1'b0; ra64 = 64'h0; ra16 = 16'h0;
    netDoneValid = 1'b0; slow = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    slow <= 1'b1;
    t_route(1'b1);
    ahb(1, 32'h0, 32'h0);
    t_route(1'b0);
    ahb(1, 32'h0, 32'h1);
    slow <= 1'b0;
    t_xmit;
    conclude;
  end
endmodule // test_rzf_top
